/* File: core/ssm_pin_sync.sv */
/*
 * Three-stage synchroniser for asynchronous pin levels.
 * Assumes inputs may change at any time relative to i_clock.
 */
`timescale 1ns/10ps
module ssm_pin_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic i_clock,
	input  wire logic i_resetn,
	ssm_sync_if.sync_side sync_port
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg;

	// First stage feeds only the second
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			stage1_reg <= RESET_VALUE;
			stage2_reg <= RESET_VALUE;
			stage3_reg <= RESET_VALUE;
		end else begin
			stage1_reg <= sync_port.async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A change counts once the last two stages agree
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			level_reg <= RESET_VALUE;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_reg[i] <= stage3_reg[i];
				end
			end
		end
	end

	assign sync_port.sync_out = level_reg;

endmodule // ssm_pin_sync

/* File: core/ssm_pkg.sv */
/*
 * Shared constants for the system status and mode control register pair:
 * register addresses, field positions, reset values and pin sync lanes.
 * Assumes a 16-bit word-addressed peripheral space on the core clock.
 */
package ssm_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// Register addresses, word indexed
	localparam logic [ADDR_W-1:0] MODE_CONTROL_ADDR  = 16'h2015;
	localparam logic [ADDR_W-1:0] SYSTEM_STATUS_ADDR = 16'h2016;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR  = 16'h2070;
	localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR    = 16'h2071;

	// Mode control fields
	localparam int MODE_LSB         = 4;
	localparam int MODE_MSB         = 6;
	localparam int MODE_RX_SEL_BIT  = 4;
	localparam int MODE_UART_BIT    = 5;
	localparam int MODE_DBL_UPD_BIT = 6;
	localparam logic [MODE_MSB:MODE_LSB] MODE_CONTROL_RESET = 3'h0;

	// System status fields, also the event bit layout
	localparam int STAT_W        = 4;
	localparam int STAT_TRIP_BIT = 0;
	localparam int STAT_WDOG_BIT = 1;
	localparam int STAT_POL_BIT  = 2;
	localparam int STAT_HALF_BIT = 3;
	localparam logic [STAT_W-1:0] EVENT_MASK_RESET = 4'h0;

	// Pin synchroniser lanes
	localparam int SYNC_W     = 5;
	localparam int SYNC_TRIP  = 0;
	localparam int SYNC_POL   = 1;
	localparam int SYNC_RX_A  = 2;
	localparam int SYNC_RX_B  = 3;
	localparam int SYNC_RFS   = 4;
	// Trip and polarity idle high: no trip, active high outputs
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h03;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
	                                  input logic [ADDR_W-1:0] target);
		addr_hit = (addr == target);
	endfunction

endpackage

/* File: core/ssm_status_mode_regs.sv */
/*
 * Mode control and system status registers with pin steering for the
 * serial port, PWM status mirroring and a small event interrupt unit.
 * Assumes a single-cycle strobe bus master on i_clock, a PWM generator
 * and watchdog on the same clock, and asynchronous pins.
 */
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// [R1] Status bit 0 mirrors the shutdown pin; one means no trip.
// [R2] Status bit 0 low means PWM outputs are held shut down.
// [R3] Status bit 1 sets after a watchdog timeout.
// [R4] Without a watchdog timeout status bit 1 reads zero.
// [R5] Status bit 2 mirrors the polarity pin; one means active high PWM.
// [R6] Status bit 3 shows the current PWM half cycle.
// [R7] Mode control at 0x2015 holds bits 6 to 4, steering port and PWM.
// [R8] System status at 0x2016 shows bits 3 to 0.
// [R9] Mode bit 4 picks receive pin B when set, pin A when clear.
// [R10] Mode bit 5 gives UART mode: receive tied to frame sync, flag drives ROM reset.
// [R11] Mode bit 6 selects the PWM double update mode.
// [R12] Writes to the status register change nothing.
module ssm_status_mode_regs
	import ssm_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	input  wire logic [ADDR_W-1:0] i_address,
	input  wire logic [DATA_W-1:0] i_write_data,
	input  wire logic              i_write_strobe,
	input  wire logic              i_read_strobe,
	output logic      [DATA_W-1:0] o_read_data,
	input  wire logic              i_pwm_shutdown_pin,
	input  wire logic              i_pwm_polarity_pin,
	input  wire logic              i_pwm_half_cycle,
	input  wire logic              i_watchdog_timeout,
	input  wire logic              i_serial_rx_pin_a,
	input  wire logic              i_serial_rx_pin_b,
	input  wire logic              i_serial_rom_reset_pin,
	output logic                   o_serial_rom_reset_pin,
	output logic                   o_serial_rom_reset_pin_oe,
	input  wire logic              i_sport_frame_sync_out,
	input  wire logic              i_sport_frame_sync_oe,
	input  wire logic              i_software_flag_one,
	output logic                   o_internal_receive_input,
	output logic                   o_receive_frame_sync,
	output logic                   o_pwm_shutdown,
	output logic                   o_pwm_active_high,
	output logic                   o_pwm_double_update,
	output logic                   o_uart_mode,
	output logic                   o_interrupt
);

	logic [MODE_MSB:MODE_LSB] mode_control_reg;
	logic                     watchdog_flag_reg;
	logic [STAT_W-1:0]        event_status_reg;
	logic [STAT_W-1:0]        event_status_next;
	logic [STAT_W-1:0]        event_mask_reg;
	logic [STAT_W-1:0]        event_pulse;
	logic [STAT_W-1:0]        system_status;
	logic                     trip_prev_reg;
	logic                     polarity_prev_reg;
	logic                     half_prev_reg;
	logic [DATA_W-1:0]        read_next;
	logic                     trip_level;
	logic                     polarity_level;
	logic                     rx_a_level;
	logic                     rx_b_level;
	logic                     rfs_pin_level;
	logic                     rx_selected;
	logic                     write_mode;
	logic                     write_event_status;
	logic                     write_event_mask;

	ssm_sync_if #(.WIDTH(SYNC_W)) pins_if ();

	// Pins are asynchronous, so every level is filtered first
	assign pins_if.async_in[SYNC_TRIP] = i_pwm_shutdown_pin;
	assign pins_if.async_in[SYNC_POL]  = i_pwm_polarity_pin;
	assign pins_if.async_in[SYNC_RX_A] = i_serial_rx_pin_a;
	assign pins_if.async_in[SYNC_RX_B] = i_serial_rx_pin_b;
	assign pins_if.async_in[SYNC_RFS]  = i_serial_rom_reset_pin;

	ssm_pin_sync #(
		.WIDTH       (SYNC_W),
		.RESET_VALUE (SYNC_RESET)
	) u_pin_sync (
		.i_clock   (i_clock),
		.i_resetn  (i_resetn),
		.sync_port (pins_if.sync_side)
	);

	assign trip_level     = pins_if.sync_out[SYNC_TRIP];
	assign polarity_level = pins_if.sync_out[SYNC_POL];
	assign rx_a_level     = pins_if.sync_out[SYNC_RX_A];
	assign rx_b_level     = pins_if.sync_out[SYNC_RX_B];
	assign rfs_pin_level  = pins_if.sync_out[SYNC_RFS];

	// [R12] Status writes ignored
	// Status address is deliberately absent from the write decode
	assign write_mode         = i_write_strobe && addr_hit(i_address, MODE_CONTROL_ADDR);
	assign write_event_status = i_write_strobe && addr_hit(i_address, EVENT_STATUS_ADDR);
	assign write_event_mask   = i_write_strobe && addr_hit(i_address, EVENT_MASK_ADDR);

	// [R7] Mode control storage
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_control_reg <= MODE_CONTROL_RESET;
		end else if (write_mode) begin
			mode_control_reg <= i_write_data[MODE_MSB:MODE_LSB];
		end
	end

	// [R3] Watchdog flag set
	// [R4] Cleared only by reset
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			watchdog_flag_reg <= 1'b0;
		end else if (i_watchdog_timeout) begin
			watchdog_flag_reg <= 1'b1;
		end
	end

	// [R1] Status assembly from live levels
	// [R5] Polarity pin level
	// [R6] PWM half cycle
	always_comb begin
		system_status                = '0;
		system_status[STAT_TRIP_BIT] = trip_level;
		system_status[STAT_WDOG_BIT] = watchdog_flag_reg;
		system_status[STAT_POL_BIT]  = polarity_level;
		system_status[STAT_HALF_BIT] = i_pwm_half_cycle;
	end

	// Edge history for the event unit
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			trip_prev_reg     <= SYNC_RESET[SYNC_TRIP];
			polarity_prev_reg <= SYNC_RESET[SYNC_POL];
			half_prev_reg     <= 1'b0;
		end else begin
			trip_prev_reg     <= trip_level;
			polarity_prev_reg <= polarity_level;
			half_prev_reg     <= i_pwm_half_cycle;
		end
	end

	always_comb begin
		event_pulse                = '0;
		event_pulse[STAT_TRIP_BIT] = trip_prev_reg && !trip_level;
		event_pulse[STAT_WDOG_BIT] = i_watchdog_timeout;
		event_pulse[STAT_POL_BIT]  = polarity_prev_reg ^ polarity_level;
		event_pulse[STAT_HALF_BIT] = half_prev_reg ^ i_pwm_half_cycle;
	end

	// Write one to clear; a new event in the same cycle wins
	always_comb begin
		event_status_next = event_status_reg | event_pulse;
		if (write_event_status) begin
			event_status_next = (event_status_reg & ~i_write_data[STAT_W-1:0]) | event_pulse;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			event_status_reg <= '0;
		end else begin
			event_status_reg <= event_status_next;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			event_mask_reg <= EVENT_MASK_RESET;
		end else if (write_event_mask) begin
			event_mask_reg <= i_write_data[STAT_W-1:0];
		end
	end

	// Registered output costs one cycle of interrupt latency
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_interrupt <= 1'b0;
		end else begin
			o_interrupt <= |(event_status_reg & event_mask_reg);
		end
	end

	// [R8] Read decode, unmapped reads zero
	always_comb begin
		read_next = '0;
		if (addr_hit(i_address, MODE_CONTROL_ADDR)) begin
			read_next[MODE_MSB:MODE_LSB] = mode_control_reg;
		end else if (addr_hit(i_address, SYSTEM_STATUS_ADDR)) begin
			read_next[STAT_W-1:0] = system_status;
		end else if (addr_hit(i_address, EVENT_STATUS_ADDR)) begin
			read_next[STAT_W-1:0] = event_status_reg;
		end else if (addr_hit(i_address, EVENT_MASK_ADDR)) begin
			read_next[STAT_W-1:0] = event_mask_reg;
		end
	end

	// Read data stand for exactly the cycle after the strobe
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_read_data <= '0;
		end else if (i_read_strobe) begin
			o_read_data <= read_next;
		end else begin
			o_read_data <= '0;
		end
	end

	// [R9] Receive pin select
	assign rx_selected = mode_control_reg[MODE_RX_SEL_BIT] ? rx_b_level : rx_a_level;

	// [R10] UART steering of frame sync and ROM reset pin
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_internal_receive_input  <= 1'b0;
			o_receive_frame_sync      <= 1'b0;
			o_serial_rom_reset_pin    <= 1'b0;
			o_serial_rom_reset_pin_oe <= 1'b0;
			o_uart_mode               <= 1'b0;
		end else begin
			o_internal_receive_input <= rx_selected;
			o_uart_mode              <= mode_control_reg[MODE_UART_BIT];
			if (mode_control_reg[MODE_UART_BIT]) begin
				o_receive_frame_sync      <= rx_selected;
				o_serial_rom_reset_pin    <= i_software_flag_one;
				o_serial_rom_reset_pin_oe <= 1'b1;
			end else begin
				o_receive_frame_sync      <= rfs_pin_level;
				o_serial_rom_reset_pin    <= i_sport_frame_sync_out;
				o_serial_rom_reset_pin_oe <= i_sport_frame_sync_oe;
			end
		end
	end

	// [R2] Trip shutdown
	// [R11] Update mode select
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pwm_shutdown      <= 1'b0;
			o_pwm_active_high   <= 1'b1;
			o_pwm_double_update <= 1'b0;
		end else begin
			o_pwm_shutdown      <= !trip_level;
			o_pwm_active_high   <= polarity_level;
			o_pwm_double_update <= mode_control_reg[MODE_DBL_UPD_BIT];
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	property p_trip_read;
		i_read_strobe && addr_hit(i_address, SYSTEM_STATUS_ADDR)
			|=> o_read_data[STAT_TRIP_BIT] == $past(trip_level);
	endproperty
	a_trip_read: assert property (p_trip_read) // [R1]
		else $error("status bit 0 differs from shutdown pin");

	property p_shutdown;
		!trip_level ##1 !trip_level |-> o_pwm_shutdown;
	endproperty
	a_shutdown: assert property (p_shutdown) // [R2]
		else $error("trip low but PWM not shut down");

	property p_wdog_set;
		i_watchdog_timeout |=> watchdog_flag_reg [*3];
	endproperty
	a_wdog_set: assert property (p_wdog_set) // [R3]
		else $error("watchdog flag not held after timeout");

	property p_wdog_quiet;
		!watchdog_flag_reg && !i_watchdog_timeout |=> !watchdog_flag_reg;
	endproperty
	a_wdog_quiet: assert property (p_wdog_quiet) // [R4]
		else $error("watchdog flag set without timeout");

	property p_pol_read;
		i_read_strobe && addr_hit(i_address, SYSTEM_STATUS_ADDR)
			|=> o_read_data[STAT_POL_BIT] == $past(polarity_level)
			&& o_read_data[STAT_WDOG_BIT] == $past(watchdog_flag_reg);
	endproperty
	a_pol_read: assert property (p_pol_read) // [R5]
		else $error("status bit 2 differs from polarity pin");

	property p_half_read;
		i_read_strobe && addr_hit(i_address, SYSTEM_STATUS_ADDR)
			|=> o_read_data[STAT_HALF_BIT] == $past(i_pwm_half_cycle);
	endproperty
	a_half_read: assert property (p_half_read) // [R6]
		else $error("status bit 3 differs from half cycle");

	property p_mode_write;
		write_mode |=> mode_control_reg == $past(i_write_data[MODE_MSB:MODE_LSB])
			##1 o_pwm_double_update == $past(mode_control_reg[MODE_DBL_UPD_BIT]);
	endproperty
	a_mode_write: assert property (p_mode_write) // [R7]
		else $error("mode control write not taken");

	property p_status_upper;
		i_read_strobe && addr_hit(i_address, SYSTEM_STATUS_ADDR)
			|=> o_read_data[DATA_W-1:STAT_W] == '0
			##1 ($past(i_read_strobe) || o_read_data == '0);
	endproperty
	a_status_upper: assert property (p_status_upper) // [R8]
		else $error("status read shows upper bits or lingers");

	property p_rx_select;
		##1 o_internal_receive_input == ($past(mode_control_reg[MODE_RX_SEL_BIT])
			? $past(rx_b_level) : $past(rx_a_level));
	endproperty
	a_rx_select: assert property (p_rx_select) // [R9]
		else $error("receive input from wrong pin");

	property p_uart;
		mode_control_reg[MODE_UART_BIT] |=> o_serial_rom_reset_pin_oe
			&& o_serial_rom_reset_pin == $past(i_software_flag_one)
			&& o_receive_frame_sync == o_internal_receive_input;
	endproperty
	a_uart: assert property (p_uart) // [R10]
		else $error("UART mode steering wrong");

	property p_dbl_update;
		$changed(mode_control_reg[MODE_DBL_UPD_BIT])
			|=> o_pwm_double_update == $past(mode_control_reg[MODE_DBL_UPD_BIT]);
	endproperty
	a_dbl_update: assert property (p_dbl_update) // [R11]
		else $error("update mode output not following bit 6");

	property p_status_write;
		i_write_strobe && addr_hit(i_address, SYSTEM_STATUS_ADDR) && !i_watchdog_timeout
			|=> $stable(mode_control_reg) && $stable(watchdog_flag_reg)
			&& $stable(event_mask_reg);
	endproperty
	a_status_write: assert property (p_status_write) // [R12]
		else $error("status write changed state");

endmodule // ssm_status_mode_regs

/* File: core/ssm_sync_if.sv */
/*
 * Carrier between the register block and its pin synchroniser.
 * Assumes both ends run on the one core clock.
 */
`timescale 1ns/10ps
interface ssm_sync_if #(parameter int WIDTH = 1);
	logic [WIDTH-1:0] async_in;
	logic [WIDTH-1:0] sync_out;
	modport sync_side (input async_in, output sync_out);
	modport user_side (output async_in, input sync_out);
endinterface // ssm_sync_if

/* File: test/ssm_core_model.sv */
/*
 * Processor core model: the bus master that reaches the mode control,
 * status, event status and event mask registers.
 * Assumes single-cycle strobes and read data standing one cycle later.
 */
`timescale 1ns/10ps
module ssm_core_model
	import ssm_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic [DATA_W-1:0] i_read_data,
	output logic      [ADDR_W-1:0] o_address,
	output logic      [DATA_W-1:0] o_write_data,
	output logic                   o_write_strobe,
	output logic                   o_read_strobe
);
	initial begin
		o_address = '0;
		o_write_data = '0;
		o_write_strobe = 1'b0;
		o_read_strobe = 1'b0;
	end

	// Callers let an edge pass before a second write, so the strobe never flips twice at once
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		o_address <= a;
		o_write_data <= d;
		o_write_strobe <= 1'b1;
		@(posedge i_clock);
		o_write_strobe <= 1'b0;
		o_write_data <= ~d;
	endtask

	// Released address shows its inverse so stale values cannot pass
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		o_address <= a;
		o_read_strobe <= 1'b1;
		@(posedge i_clock);
		o_read_strobe <= 1'b0;
		o_address <= ~a;
		@(posedge i_clock);
		d = i_read_data;
	endtask
endmodule // ssm_core_model

/* File: test/tb.sv */
/*
 * Self-checking bench for the status and mode control registers.
 * Assumes the core model as bus master and pins driven from here.
 */
`timescale 1ns/10ps
module tb;
	import ssm_pkg::*;

	typedef struct {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
	} ssm_row_s;

	logic              i_clock  = 1'b0;
	logic              i_resetn = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              we;
	logic              re;
	logic              trip     = 1'b1;
	logic              pol      = 1'b1;
	logic              half     = 1'b0;
	logic              wd       = 1'b0;
	logic              rxa      = 1'b1;
	logic              rxb      = 1'b0;
	logic              flag     = 1'b0;
	logic              rom_in   = 1'b0;
	logic              fs_out   = 1'b0;
	logic              fs_oe    = 1'b0;
	logic              rom;
	logic              rom_oe;
	logic              rx_in;
	logic              rfs;
	logic              shut;
	logic              act_hi;
	logic              dbl;
	logic              uart;
	logic              irq;
	int                failures = 0;
	int                n_checks = 0;
	int                cycles   = 0;
	ssm_row_s          rows [5] = '{
		'{MODE_CONTROL_ADDR, 16'h0070, 16'h0070},
		'{MODE_CONTROL_ADDR, 16'hFF8F, 16'h0000},
		'{SYSTEM_STATUS_ADDR, 16'h000A, 16'h0005},
		'{16'h2017, 16'hFFFF, 16'h0000},
		'{EVENT_MASK_ADDR, 16'hFFFF, 16'h000F}};

	always #2 i_clock = ~i_clock;

	ssm_core_model core (.i_clock(i_clock), .i_read_data(rdata), .o_address(addr),
		.o_write_data(wdata), .o_write_strobe(we), .o_read_strobe(re));

	ssm_status_mode_regs uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(addr),
		.i_write_data(wdata), .i_write_strobe(we), .i_read_strobe(re), .o_read_data(rdata),
		.i_pwm_shutdown_pin(trip), .i_pwm_polarity_pin(pol), .i_pwm_half_cycle(half),
		.i_watchdog_timeout(wd), .i_serial_rx_pin_a(rxa), .i_serial_rx_pin_b(rxb),
		.i_serial_rom_reset_pin(rom_in), .o_serial_rom_reset_pin(rom),
		.o_serial_rom_reset_pin_oe(rom_oe), .i_sport_frame_sync_out(fs_out),
		.i_sport_frame_sync_oe(fs_oe), .i_software_flag_one(flag),
		.o_internal_receive_input(rx_in), .o_receive_frame_sync(rfs), .o_pwm_shutdown(shut),
		.o_pwm_active_high(act_hi), .o_pwm_double_update(dbl), .o_uart_mode(uart),
		.o_interrupt(irq));

	task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
	                     input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	task automatic note(input string name);
		$display("test %s done", name);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole run needs about a hundred cycles, well short of the 2000-cycle budget that stops a hang
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			results();
		end
	end

	initial begin
		logic [DATA_W-1:0] d;
		ticks(3);
		chk1(act_hi, 1'b1, "reset polarity");
		chk1(irq, 1'b0, "reset interrupt");
		ticks(3);
		i_resetn <= 1'b1;
		ticks(8);
		core.rd(MODE_CONTROL_ADDR, d);
		chk16(d, 16'h0000, "mode reset value");
		note("reset");
		foreach (rows[i]) begin
			core.wr(rows[i].a, rows[i].d);
			core.rd(rows[i].a, d);
			chk16(d, rows[i].e, "row readback");
		end
		note("table");
		wd <= 1'b1;
		ticks(1);
		wd <= 1'b0;
		ticks(2);
		core.rd(SYSTEM_STATUS_ADDR, d);
		chk16(d, 16'h0007, "watchdog flag");
		note("watchdog");
		core.wr(EVENT_STATUS_ADDR, 16'h000F);
		ticks(3);
		chk1(irq, 1'b0, "events cleared");
		trip <= 1'b0;
		ticks(8);
		chk1(shut, 1'b1, "shutdown held");
		core.rd(SYSTEM_STATUS_ADDR, d);
		chk16(d, 16'h0006, "trip status");
		core.rd(EVENT_STATUS_ADDR, d);
		chk16(d, 16'h0001, "trip event");
		chk1(irq, 1'b1, "trip interrupt");
		core.wr(EVENT_MASK_ADDR, 16'h0000);
		ticks(3);
		chk1(irq, 1'b0, "masked");
		core.wr(EVENT_MASK_ADDR, 16'h0001);
		ticks(3);
		chk1(irq, 1'b1, "unmasked");
		core.wr(EVENT_STATUS_ADDR, 16'h0001);
		ticks(3);
		chk1(irq, 1'b0, "write one clears");
		trip <= 1'b1;
		note("trip");
		pol <= 1'b0;
		half <= 1'b1;
		rom_in <= 1'b1;
		fs_out <= 1'b1;
		fs_oe <= 1'b1;
		ticks(8);
		chk1(shut, 1'b0, "trip released");
		chk1(act_hi, 1'b0, "polarity low");
		core.rd(SYSTEM_STATUS_ADDR, d);
		chk16(d, 16'h000B, "polarity and half");
		note("polarity");
		chk1(rx_in, 1'b1, "pin a routed");
		core.wr(MODE_CONTROL_ADDR, 16'h0010);
		ticks(3);
		chk1(rx_in, 1'b0, "pin b routed");
		chk1(uart, 1'b0, "sport mode");
		chk1(rom_oe, 1'b1, "pin enable from sport");
		chk1(rom, 1'b1, "pin value from sport");
		chk1(rfs, 1'b1, "frame sync from pin");
		flag <= 1'b1;
		fs_out <= 1'b0;
		fs_oe <= 1'b0;
		rom_in <= 1'b0;
		core.wr(MODE_CONTROL_ADDR, 16'h0060);
		ticks(6);
		chk1(uart, 1'b1, "uart mode");
		chk1(rom_oe, 1'b1, "rom reset driven");
		chk1(rom, 1'b1, "flag on rom reset");
		chk1(rfs, 1'b1, "receive tied to sync");
		chk1(dbl, 1'b1, "double update");
		core.rd(MODE_CONTROL_ADDR, d);
		chk16(d, 16'h0060, "mode readback");
		note("routing");
		i_resetn <= 1'b0;
		ticks(2);
		chk1(uart, 1'b0, "reset uart mode");
		chk1(rom_oe, 1'b0, "reset pin released");
		chk1(dbl, 1'b0, "reset update mode");
		i_resetn <= 1'b1;
		ticks(8);
		core.rd(SYSTEM_STATUS_ADDR, d);
		chk16(d, 16'h0009, "watchdog cleared by reset");
		core.rd(MODE_CONTROL_ADDR, d);
		chk16(d, 16'h0000, "mode after reset");
		note("mid reset");
		results();
	end
endmodule // tb
